//--- alu_if.sv
// interface: operands and results between the sequencer and the flag unit
`timescale 1ns/1ps
`default_nettype none
interface alu_if;
    import cpu_dec_pkg::*;
    aluop_t     op;
    logic [7:0] a;
    logic [7:0] b;
    logic [7:0] ccrIn;
    logic [7:0] res;
    logic [7:0] ccrOut;
    modport core (output op, a, b, ccrIn, input res, ccrOut);
    modport unit (input op, a, b, ccrIn, output res, ccrOut);
endinterface
`default_nettype wire

//--- cpu_dec_pkg.sv
// package: opcodes, encodings, reset values and vectors of the decode core
package cpu_dec_pkg;
    typedef enum logic [3:0] {
        M_INH  = 4'b0000, M_IMM  = 4'b0001, M_DIR  = 4'b0010,
        M_EXT  = 4'b0011, M_IX2  = 4'b0100, M_IX1  = 4'b0101,
        M_IX   = 4'b0110, M_SP1  = 4'b0111, M_SP2  = 4'b1000,
        M_IXP  = 4'b1001, M_IX1P = 4'b1010, M_DIXP = 4'b1011,
        M_IXPD = 4'b1100, M_IMD  = 4'b1101
    } mode_t;
    typedef enum logic [3:0] {
        K_NONE = 4'b0000, K_SUB  = 4'b0001, K_TST  = 4'b0010,
        K_STX  = 4'b0011, K_MOV  = 4'b0100, K_CBEQ = 4'b0101,
        K_BRBIT = 4'b0110, K_SWI = 4'b0111, K_STOP = 4'b1000,
        K_TAP  = 4'b1001, K_TPA  = 4'b1010, K_TAX  = 4'b1011,
        K_TXA  = 4'b1100, K_TSX  = 4'b1101, K_TXS  = 4'b1110
    } kind_t;
    typedef enum logic [3:0] {
        S_FETCH = 4'b0000, S_PREFIX = 4'b0001, S_OPHI = 4'b0010,
        S_OPLO  = 4'b0011, S_READ   = 4'b0100, S_WRITE = 4'b0101,
        S_DST   = 4'b0110, S_BRREL  = 4'b0111, S_PUSH  = 4'b1000,
        S_VECHI = 4'b1001, S_VECLO  = 4'b1010, S_STOP  = 4'b1011
    } state_t;
    typedef enum logic {A_SUB = 1'b0, A_TST = 1'b1} aluop_t;
    typedef struct packed {mode_t mode; kind_t kind;} dec_t;

    localparam logic [7:0] OP_PREFIX   = 8'h9E;
    localparam logic [7:0] OP_STOP     = 8'h8E;
    localparam logic [7:0] OP_SWI      = 8'h83;
    localparam logic [7:0] OP_TAP      = 8'h84;
    localparam logic [7:0] OP_TPA      = 8'h85;
    localparam logic [7:0] OP_TAX      = 8'h97;
    localparam logic [7:0] OP_TXA      = 8'h9F;
    localparam logic [7:0] OP_TSX      = 8'h95;
    localparam logic [7:0] OP_TXS      = 8'h94;
    localparam logic [7:0] OP_TST_SP1  = 8'h6D;
    localparam logic [7:0] OP_CBEQ_DIR = 8'h31;
    localparam logic [7:0] OP_CBEQ_IX1P = 8'h61;
    localparam logic [7:0] OP_CBEQ_IXP = 8'h71;
    localparam logic [7:0] OP_MOV_DD   = 8'h4E;
    localparam logic [7:0] OP_MOV_DIXP = 8'h5E;
    localparam logic [7:0] OP_MOV_IMD  = 8'h6E;
    localparam logic [7:0] OP_MOV_IXPD = 8'h7E;
    localparam logic [3:0] LO_SUB = 4'h0;
    localparam logic [3:0] LO_STX = 4'hF;
    localparam logic [3:0] LO_TST = 4'hD;
    localparam logic [3:0] NIB_BRBIT = 4'h0;
    localparam logic [3:0] NIB_IMM = 4'hA;
    localparam logic [3:0] NIB_DIR = 4'hB;
    localparam logic [3:0] NIB_EXT = 4'hC;
    localparam logic [3:0] NIB_IX2 = 4'hD;
    localparam logic [3:0] NIB_IX1 = 4'hE;
    localparam logic [3:0] NIB_IX  = 4'hF;
    localparam logic [3:0] NIB_TST_DIR = 4'h3;
    localparam logic [3:0] NIB_TST_A   = 4'h4;
    localparam logic [3:0] NIB_TST_X   = 4'h5;
    localparam logic [3:0] NIB_TST_IX1 = 4'h6;
    localparam logic [3:0] NIB_TST_IX  = 4'h7;
    localparam logic [3:0] NIB_PRE_SP1 = 4'hE;
    localparam logic [3:0] NIB_PRE_SP2 = 4'hD;

    localparam int CCR_V = 7;
    localparam int CCR_I = 3;
    localparam int CCR_N = 2;
    localparam int CCR_Z = 1;
    localparam int CCR_C = 0;
    localparam logic [7:0]  CCR_FIXED = 8'h60;
    localparam logic [7:0]  CCR_RESET = 8'h68;
    localparam logic [15:0] SP_RESET  = 16'h00FF;
    localparam logic [15:0] VEC_RESET = 16'hFFFE;
    localparam logic [15:0] VEC_TRAP  = 16'hFFFC;
    localparam logic [2:0]  PUSH_LAST = 3'h4;
endpackage

//--- cpu_decode_core.sv
// decode and execution sequencer for the instruction subset
`timescale 1ns/1ps
`default_nettype none
// Contract
// (RQ1) opcode 8E clears the interrupt mask, stops the oscillator, other flags kept.
// (RQ2) opcode 83 advances PC, pushes PCL, PCH, X, A, flags, sets I, loads vector.
// (RQ3) test-for-zero updates N and Z, clears V, keeps C, stores nothing.
// (RQ4) stack short mode addresses SP plus one offset byte after a prefix.
// (RQ5) stack long mode addresses SP plus a 16-bit offset fetched high then low.
// (RQ6) index post-increment mode addresses H:X and then increments H:X.
// (RQ7) index offset post-increment mode addresses H:X plus a byte, then H:X+1.
// (RQ8) direct-to-index move reads direct page, writes at H:X, increments H:X.
// (RQ9) index-to-direct move reads at H:X, increments H:X, writes direct page.
// (RQ10) immediate-to-direct move writes the immediate byte to direct page.
// (RQ11) extended mode fetches the address high byte then low byte.
// (RQ12) index long mode adds a 16-bit offset, high byte first, to H:X.
// (RQ13) index short mode adds one offset byte to H:X.
// (RQ14) test-and-branch fetches a direct address then a signed offset, adds if taken.
// (RQ15) subtract replaces A with A minus M and updates V, N, Z and C.
// (RQ16) store index low writes X, clears V, sets N and Z from X.
// (RQ17) transfers move A and flags, A and X, and H:X and SP with the one offset.
module cpu_decode_core (
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic [7:0]  memRdData,
    input  wire logic        wakeReq,
    output logic      [15:0] memAddr,
    output logic      [7:0]  memWrData,
    output logic             memRe,
    output logic             memWe,
    output logic             oscStopped,
    output logic      [7:0]  accOut,
    output logic      [7:0]  ccrOut
);
    import cpu_dec_pkg::*;

    state_t      state_ff, nxt_state;
    mode_t       mode_ff, nxt_mode;
    kind_t       kind_ff, nxt_kind;
    logic [15:0] pc_ff, nxt_pc, sp_ff, nxt_sp, hx_ff, nxt_hx, ea_ff, nxt_ea;
    logic [7:0]  acc_ff, nxt_acc, ccr_ff, nxt_ccr, tmp_ff, nxt_tmp;
    logic [7:0]  op_ff, nxt_op;
    logic [2:0]  cnt_ff, nxt_cnt;
    logic        wakeMeta_ff, wakeSync_ff;
    logic        dispatch, dispPre, taken;
    logic [15:0] base, offs;
    dec_t        dec;
    alu_if       alu ();

    cpu_flag_alu u_alu (.alu(alu));

    function automatic dec_t decode(input logic pre, input logic [7:0] op);
        dec_t       d;
        logic [3:0] hi;
        logic [3:0] lo;
        hi = op[7:4];
        lo = op[3:0];
        d  = '{M_INH, K_NONE};
        if (pre) begin
            if (op == OP_TST_SP1) d = '{M_SP1, K_TST};
            else if ((hi == NIB_PRE_SP1 || hi == NIB_PRE_SP2)
                     && (lo == LO_SUB || lo == LO_STX)) begin
                d.mode = (hi == NIB_PRE_SP1) ? M_SP1 : M_SP2;   // RQ4 RQ5
                d.kind = (lo == LO_SUB) ? K_SUB : K_STX;
            end
        end else if ((lo == LO_SUB && hi >= NIB_IMM)
                     || (lo == LO_STX && hi >= NIB_DIR)) begin
            d.kind = (lo == LO_SUB) ? K_SUB : K_STX;
            unique case (hi)
                NIB_IMM: d.mode = M_IMM;
                NIB_DIR: d.mode = M_DIR;
                NIB_EXT: d.mode = M_EXT;
                NIB_IX2: d.mode = M_IX2;
                NIB_IX1: d.mode = M_IX1;
                default: d.mode = M_IX;
            endcase
        end else if (lo == LO_TST && hi >= NIB_TST_DIR && hi <= NIB_TST_IX) begin
            d.kind = K_TST;
            unique case (hi)
                NIB_TST_DIR: d.mode = M_DIR;
                NIB_TST_IX1: d.mode = M_IX1;
                NIB_TST_IX:  d.mode = M_IX;
                default:     d.mode = M_INH;
            endcase
        end else if (hi == NIB_BRBIT) d = '{M_DIR, K_BRBIT};
        else begin
            case (op)
                OP_CBEQ_DIR:  d = '{M_DIR, K_CBEQ};
                OP_CBEQ_IX1P: d = '{M_IX1P, K_CBEQ};
                OP_CBEQ_IXP:  d = '{M_IXP, K_CBEQ};
                OP_MOV_DD:    d = '{M_DIR, K_MOV};
                OP_MOV_DIXP:  d = '{M_DIXP, K_MOV};
                OP_MOV_IMD:   d = '{M_IMD, K_MOV};
                OP_MOV_IXPD:  d = '{M_IXPD, K_MOV};
                OP_STOP:      d.kind = K_STOP;
                OP_SWI:       d.kind = K_SWI;
                OP_TAP:       d.kind = K_TAP;
                OP_TPA:       d.kind = K_TPA;
                OP_TAX:       d.kind = K_TAX;
                OP_TXA:       d.kind = K_TXA;
                OP_TSX:       d.kind = K_TSX;
                OP_TXS:       d.kind = K_TXS;
                default:      d.kind = K_NONE;
            endcase
        end
        return d;
    endfunction

    always_comb begin
        nxt_state = state_ff;  nxt_mode = mode_ff;  nxt_kind = kind_ff;
        nxt_pc = pc_ff;  nxt_sp = sp_ff;  nxt_hx = hx_ff;  nxt_ea = ea_ff;
        nxt_acc = acc_ff;  nxt_ccr = ccr_ff;  nxt_tmp = tmp_ff;
        nxt_op = op_ff;  nxt_cnt = cnt_ff;
        memAddr = pc_ff;  memRe = 1'b0;  memWe = 1'b0;  memWrData = tmp_ff;
        alu.op = A_TST;  alu.a = acc_ff;  alu.b = memRdData;
        alu.ccrIn = ccr_ff;
        dispatch = 1'b0;  dispPre = 1'b0;  taken = 1'b0;
        dec = decode(1'b0, memRdData);
        base = 16'h0000;
        offs = {8'h00, memRdData};
        unique case (state_ff)
            S_FETCH: begin
                memRe  = 1'b1;
                nxt_pc = pc_ff + 16'h0001;                          // RQ2
                nxt_op = memRdData;
                if (memRdData == OP_PREFIX) nxt_state = S_PREFIX;
                else dispatch = 1'b1;
            end
            S_PREFIX: begin
                memRe    = 1'b1;
                nxt_pc   = pc_ff + 16'h0001;
                nxt_op   = memRdData;
                dispatch = 1'b1;
                dispPre  = 1'b1;
            end
            S_OPHI: begin
                memRe     = 1'b1;
                nxt_pc    = pc_ff + 16'h0001;
                nxt_ea    = {memRdData, 8'h00};          // RQ5 RQ11 RQ12
                nxt_state = S_OPLO;
            end
            S_OPLO: begin
                memRe  = 1'b1;
                nxt_pc = pc_ff + 16'h0001;
                if (mode_ff == M_IX2 || mode_ff == M_IX1 || mode_ff == M_IX1P)
                    base = hx_ff;                            // RQ7 RQ12 RQ13
                else if (mode_ff == M_SP1 || mode_ff == M_SP2)
                    base = sp_ff;                                   // RQ4 RQ5
                if (mode_ff == M_EXT || mode_ff == M_IX2 || mode_ff == M_SP2)
                    offs = {ea_ff[15:8], memRdData};             // RQ11 RQ12
                nxt_ea = base + offs;
                if (mode_ff == M_IMM || mode_ff == M_IMD) begin
                    nxt_tmp = memRdData;                            // RQ10
                    if (kind_ff == K_SUB) begin
                        alu.op    = A_SUB;
                        nxt_acc   = alu.res;                        // RQ15
                        nxt_ccr   = alu.ccrOut;
                        nxt_state = S_FETCH;
                    end else nxt_state = S_DST;
                end else nxt_state = (kind_ff == K_STX) ? S_WRITE : S_READ;
            end
            S_READ: begin
                memAddr   = ea_ff;
                memRe     = 1'b1;
                nxt_tmp   = memRdData;
                nxt_state = S_FETCH;
                case (kind_ff)
                    K_SUB: begin
                        alu.op  = A_SUB;
                        nxt_acc = alu.res;                          // RQ15
                        nxt_ccr = alu.ccrOut;
                    end
                    K_TST: nxt_ccr = alu.ccrOut;                     // RQ3
                    K_CBEQ, K_BRBIT: begin
                        if (mode_ff == M_IXP || mode_ff == M_IX1P)
                            nxt_hx = hx_ff + 16'h0001;             // RQ6 RQ7
                        nxt_state = S_BRREL;                        // RQ14
                    end
                    K_MOV: begin
                        if (mode_ff == M_DIXP) begin
                            nxt_ea    = hx_ff;                      // RQ8
                            nxt_state = S_WRITE;
                        end else begin
                            if (mode_ff == M_IXPD)
                                nxt_hx = hx_ff + 16'h0001;          // RQ9
                            nxt_state = S_DST;
                        end
                    end
                    default: nxt_state = S_FETCH;
                endcase
            end
            S_DST: begin
                memRe     = 1'b1;
                nxt_pc    = pc_ff + 16'h0001;
                nxt_ea    = {8'h00, memRdData};          // RQ9 RQ10
                nxt_state = S_WRITE;
            end
            S_WRITE: begin
                memAddr   = ea_ff;
                memWe     = 1'b1;
                memWrData = (kind_ff == K_STX) ? hx_ff[7:0] : tmp_ff; // RQ16
                alu.b     = memWrData;
                nxt_ccr   = alu.ccrOut;                             // RQ16
                if (mode_ff == M_DIXP) nxt_hx = hx_ff + 16'h0001;   // RQ8
                nxt_state = S_FETCH;
            end
            S_BRREL: begin
                memRe  = 1'b1;
                if (kind_ff == K_CBEQ) taken = (acc_ff == tmp_ff);
                else begin
                    // bit number sits in opcode bits 3:1, bit 0 picks clear
                    taken = tmp_ff[op_ff[3:1]] ^ op_ff[0];
                    nxt_ccr[CCR_C] = tmp_ff[op_ff[3:1]];
                end
                nxt_pc = pc_ff + 16'h0001
                       + (taken ? {{8{memRdData[7]}}, memRdData} : 16'h0000);
                nxt_state = S_FETCH;                                // RQ14
            end
            S_PUSH: begin
                memAddr = sp_ff;
                memWe   = 1'b1;
                unique case (cnt_ff)
                    3'h0:    memWrData = pc_ff[7:0];
                    3'h1:    memWrData = pc_ff[15:8];
                    3'h2:    memWrData = hx_ff[7:0];
                    3'h3:    memWrData = acc_ff;
                    default: memWrData = ccr_ff;
                endcase
                nxt_sp  = sp_ff - 16'h0001;                         // RQ2
                nxt_cnt = cnt_ff + 3'h1;
                if (cnt_ff == PUSH_LAST) begin
                    nxt_ccr[CCR_I] = 1'b1;                          // RQ2
                    nxt_ea         = VEC_TRAP;
                    nxt_state      = S_VECHI;
                end
            end
            S_VECHI: begin
                memAddr   = ea_ff;
                memRe     = 1'b1;
                nxt_pc    = {memRdData, pc_ff[7:0]};                // RQ2
                nxt_state = S_VECLO;
            end
            S_VECLO: begin
                memAddr   = ea_ff + 16'h0001;
                memRe     = 1'b1;
                nxt_pc    = {pc_ff[15:8], memRdData};
                nxt_state = S_FETCH;
            end
            S_STOP: begin
                // only the synchronised wake level leaves stop
                if (wakeSync_ff) nxt_state = S_FETCH;
            end
            default: nxt_state = S_FETCH;
        endcase
        if (dispatch) begin
            dec      = decode(dispPre, memRdData);
            nxt_mode = dec.mode;
            nxt_kind = dec.kind;
            unique case (dec.mode)
                M_INH: begin
                    unique case (dec.kind)
                        K_STOP: begin
                            nxt_ccr[CCR_I] = 1'b0;                  // RQ1
                            nxt_state      = S_STOP;                // RQ1
                        end
                        K_SWI: begin
                            nxt_cnt   = 3'h0;
                            nxt_state = S_PUSH;                     // RQ2
                        end
                        K_TAP: nxt_ccr = acc_ff | CCR_FIXED;        // RQ17
                        K_TPA: nxt_acc = ccr_ff;                    // RQ17
                        K_TAX: nxt_hx  = {hx_ff[15:8], acc_ff};     // RQ17
                        K_TXA: nxt_acc = hx_ff[7:0];                // RQ17
                        K_TSX: nxt_hx  = sp_ff + 16'h0001;          // RQ17
                        K_TXS: nxt_sp  = hx_ff - 16'h0001;          // RQ17
                        K_TST: begin
                            alu.b   = (memRdData[7:4] == NIB_TST_A)
                                    ? acc_ff : hx_ff[7:0];
                            nxt_ccr = alu.ccrOut;                   // RQ3
                        end
                        default: nxt_state = S_FETCH;
                    endcase
                end
                M_EXT, M_IX2, M_SP2: nxt_state = S_OPHI;
                M_IX, M_IXP, M_IXPD: begin
                    // index-to-direct reads at H:X before its one dd byte
                    nxt_ea    = hx_ff;                          // RQ6 RQ9
                    nxt_state = (dec.kind == K_STX) ? S_WRITE : S_READ;
                end
                default: nxt_state = S_OPLO;
            endcase
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_ff <= S_VECHI;  mode_ff <= M_INH;  kind_ff <= K_NONE;
            pc_ff <= 16'h0000;  sp_ff <= SP_RESET;  hx_ff <= 16'h0000;
            ea_ff <= VEC_RESET;  acc_ff <= 8'h00;  ccr_ff <= CCR_RESET;
            tmp_ff <= 8'h00;  op_ff <= 8'h00;  cnt_ff <= 3'h0;
            wakeMeta_ff <= 1'b0;  wakeSync_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;  mode_ff <= nxt_mode;  kind_ff <= nxt_kind;
            pc_ff <= nxt_pc;  sp_ff <= nxt_sp;  hx_ff <= nxt_hx;
            ea_ff <= nxt_ea;  acc_ff <= nxt_acc;  ccr_ff <= nxt_ccr;
            tmp_ff <= nxt_tmp;  op_ff <= nxt_op;  cnt_ff <= nxt_cnt;
            wakeMeta_ff <= wakeReq;  wakeSync_ff <= wakeMeta_ff;
        end
    end

    assign oscStopped = (state_ff == S_STOP);
    assign accOut     = acc_ff;
    assign ccrOut     = ccr_ff;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    sequence trap_fetch;
        state_ff == S_FETCH && memRdData == OP_SWI;
    endsequence
    sequence five_pushes;
        memWe[*5];
    endsequence

    a_stop_mask_clr: assert property ( // RQ1
        state_ff == S_FETCH && memRdData == OP_STOP |=> oscStopped
        && !ccr_ff[CCR_I] && ccr_ff[CCR_N] == $past(ccr_ff[CCR_N]))
        else $error("stop did not clear mask or stop clock");
    a_trap_push_seq: assert property ( // RQ2
        trap_fetch |=> five_pushes ##1 state_ff == S_VECHI
        && ccr_ff[CCR_I] && memAddr == VEC_TRAP)
        else $error("trap push sequence wrong");
    a_trap_sp_drop: assert property ( // RQ2
        trap_fetch |=> ##5 sp_ff == $past(sp_ff, 5) - 16'h0005)
        else $error("trap stack pointer not lowered by five");
    a_test_flags: assert property ( // RQ3
        state_ff == S_READ && kind_ff == K_TST |=> !ccr_ff[CCR_V]
        && ccr_ff[CCR_C] == $past(ccr_ff[CCR_C])
        && acc_ff == $past(acc_ff))
        else $error("test changed carry, overflow or accumulator");
    a_sp_short_addr: assert property ( // RQ4
        state_ff == S_OPLO && mode_ff == M_SP1 |=> memAddr
        == $past(sp_ff) + {8'h00, $past(memRdData)})
        else $error("stack short address wrong");
    a_ext_addr_order: assert property ( // RQ11
        state_ff == S_OPHI && mode_ff == M_EXT |=> state_ff == S_OPLO
        ##1 memAddr[15:8] == $past(memRdData, 2))
        else $error("extended high byte not first");
    a_postinc_step: assert property ( // RQ6
        state_ff == S_READ && mode_ff == M_IXP
        |=> hx_ff == $past(hx_ff) + 16'h0001)
        else $error("index pair not incremented");
    a_dix_write: assert property ( // RQ8
        state_ff == S_WRITE && mode_ff == M_DIXP |-> memWe
        && memAddr == hx_ff ##1 hx_ff == $past(hx_ff) + 16'h0001)
        else $error("direct-to-index move wrong");
    a_store_x_data: assert property ( // RQ16
        state_ff == S_WRITE && kind_ff == K_STX |-> memWrData == hx_ff[7:0]
        ##1 !ccr_ff[CCR_V] && ccr_ff[CCR_Z] == ($past(hx_ff[7:0]) == 8'h00))
        else $error("store index low wrong");
    a_tsx_value: assert property ( // RQ17
        dispatch && dec.kind == K_TSX |=> hx_ff == $past(sp_ff) + 16'h0001)
        else $error("stack to index transfer wrong");
endmodule
`default_nettype wire

//--- cpu_decode_core_tb.sv
// testbench: runs a short program and checks results against a model
`timescale 1ns/1ps
`default_nettype none
module cpu_decode_core_tb;
    import cpu_dec_pkg::*;
    logic        clk_sys = 1'b0;
    logic        rst = 1'b1;
    logic        wakeReq = 1'b0;
    logic [7:0]  memRdData;
    logic [15:0] memAddr;
    logic [7:0]  memWrData;
    logic        memRe;
    logic        memWe;
    logic        oscStopped;
    logic [7:0]  accOut;
    logic [7:0]  ccrOut;
    int          failures = 0;
    int          checksDone = 0;
    always #12.5 clk_sys = ~clk_sys;
    cpu_decode_core dut_u (.clk_sys(clk_sys), .rst(rst),
        .memRdData(memRdData), .wakeReq(wakeReq), .memAddr(memAddr),
        .memWrData(memWrData), .memRe(memRe), .memWe(memWe),
        .oscStopped(oscStopped), .accOut(accOut), .ccrOut(ccrOut));
    cpu_mem_model mem_u (.clk_sys(clk_sys), .memAddr(memAddr),
        .memWrData(memWrData), .memRe(memRe), .memWe(memWe),
        .memRdData(memRdData));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checksDone++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen,
                exp);
        end
    endtask
    task automatic final_report();
        if (failures == 0 && checksDone > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // program runs well under 100 cycles; the limit leaves ample margin
    initial begin
        #(25 * 2000);
        failures++;
        final_report();
    end
    task automatic wait_stop(input logic lvl);
        for (int i = 0; i < 200 && oscStopped !== lvl; i++) begin
            @(negedge clk_sys);
        end
    endtask
    initial begin
        integer     seed;
        logic [7:0] imm;
        logic [7:0] r;
        logic [7:0] cc;
        logic [7:0] prog [8];
        logic [7:0] tail [17];
        seed = 32'h3d98;
        imm = $random(seed);
        r = 8'h00 - imm;
        // flags after the test and the store: V clear, C kept from borrow
        cc = CCR_RESET | {5'h0, r[7], (r == 8'h00), (imm != 8'h00)};
        prog = '{8'hA0, imm, 8'h4D, 8'h97, 8'hBF, 8'h40, 8'h85, 8'h83};
        for (int i = 0; i < 8; i++) begin
            mem_u.mem[16'h0100 + i] = prog[i];
        end
        mem_u.mem[VEC_RESET] = 8'h01;
        mem_u.mem[VEC_RESET + 16'h1] = 8'h00;
        mem_u.mem[VEC_TRAP] = 8'h02;
        mem_u.mem[VEC_TRAP + 16'h1] = 8'h00;
        // trap target: stop, then stack-relative, post-increment and move
        // forms; the taken branch skips a stop that would end the run early
        tail = '{8'h8E, 8'h95, 8'h71, 8'h01, 8'h8E, 8'h7E, 8'h60, 8'h5E,
                 8'h40, 8'h9E, 8'h6D, 8'h01, 8'hC0, 8'h00, 8'h60, 8'h9F,
                 8'h8E};
        for (int i = 0; i < 17; i++) begin
            mem_u.mem[16'h0200 + i] = tail[i];
        end
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        wait_stop(1'b1);
        check(oscStopped, 1'b1);
        check(ccrOut, cc & 8'hF7);
        check(accOut, cc);
        check(mem_u.mem[16'h0040], r);
        check(mem_u.mem[16'h00FF], 8'h08);
        check(mem_u.mem[16'h00FE], 8'h01);
        check(mem_u.mem[16'h00FD], r);
        check(mem_u.mem[16'h00FC], cc);
        check(mem_u.mem[16'h00FB], cc);
        @(posedge clk_sys);
        wakeReq <= 1'b1;
        // wake is a level: drop it before the second stop is reached
        repeat (2) @(posedge clk_sys);
        wakeReq <= 1'b0;
        wait_stop(1'b0);
        check(oscStopped, 1'b0);
        wait_stop(1'b1);
        // X is SP+1 after five pushes, stepped by three post-increments
        check(accOut, 8'hFE);
        check(ccrOut, (cc & 8'hF0) | 8'h02);
        check(mem_u.mem[16'h0060], cc);
        check(mem_u.mem[16'h00FD], r);
        repeat (4) @(negedge clk_sys);
        check(oscStopped, 1'b1);
        final_report();
    end
endmodule
`default_nettype wire

//--- cpu_flag_alu.sv
// flag unit: subtract and test/store flag update
`timescale 1ns/1ps
`default_nettype none
module cpu_flag_alu (
    alu_if.unit alu
);
    import cpu_dec_pkg::*;
    logic [7:0] diff;
    always_comb begin
        diff       = alu.a - alu.b;
        alu.ccrOut = alu.ccrIn;
        if (alu.op == A_SUB) begin
            alu.res           = diff;                                 // RQ15
            alu.ccrOut[CCR_V] = (alu.a[7] & ~alu.b[7] & ~diff[7])
                              | (~alu.a[7] & alu.b[7] & diff[7]);
            alu.ccrOut[CCR_C] = (~alu.a[7] & alu.b[7]) | (alu.b[7] & diff[7])
                              | (diff[7] & ~alu.a[7]);
        end else begin
            // operand minus zero: no borrow, carry stays
            alu.res           = alu.b;                                // RQ3
            alu.ccrOut[CCR_V] = 1'b0;
        end
        alu.ccrOut[CCR_N] = alu.res[7];
        alu.ccrOut[CCR_Z] = (alu.res == 8'h00);
    end
endmodule
`default_nettype wire

//--- cpu_mem_model.sv
// memory partner: zero-latency program and data store
`timescale 1ns/1ps
`default_nettype none
module cpu_mem_model (
    input  wire logic        clk_sys,
    input  wire logic [15:0] memAddr,
    input  wire logic [7:0]  memWrData,
    input  wire logic        memRe,
    input  wire logic        memWe,
    output logic      [7:0]  memRdData
);
    logic [7:0] mem [0:65535];
    logic [7:0] junk;
    initial junk = 8'hA5;
    // idle bus toggles so a read without strobe never looks valid
    always @(posedge clk_sys) begin
        junk <= ~junk;
        if (memWe === 1'b1) begin
            mem[memAddr] <= memWrData;
        end
    end
    assign memRdData = (memRe === 1'b1) ? mem[memAddr] : junk;
endmodule
`default_nettype wire
